// ==== hw/fspc_pkg.sv ====
package fspc_pkg;
    // ==========================================
    // register map
    localparam logic [3:0] CSR_ADDR  = 4'h0;
    localparam logic [7:0] CSR_RESET = 8'h00;

    // ==========================================
    // control and status bit positions
    localparam int BIT_IRQ_EN  = 7;
    localparam int BIT_BUSY    = 6;
    localparam int BIT_SECT_RE = 4;
    localparam int BIT_LOCK_RD = 3;
    localparam int BIT_PG_WR   = 2;
    localparam int BIT_PG_ER   = 1;
    localparam int BIT_SPE     = 0;

    // ==========================================
    // accepted lower five bit patterns
    localparam logic [4:0] PAT_LOAD   = 5'h01;
    localparam logic [4:0] PAT_ERASE  = 5'h03;
    localparam logic [4:0] PAT_WRITE  = 5'h05;
    localparam logic [4:0] PAT_LOCKRD = 5'h09;
    localparam logic [4:0] PAT_CLRBUF = 5'h11;

    // ==========================================
    // arming windows, counted down from ARM_CYCLES
    localparam logic [2:0] ARM_CYCLES = 3'h4;
    localparam logic [2:0] LOAD_WIN   = 3'h2;

    // ==========================================
    // pointer codes for fuse and lock reads
    localparam logic [1:0] PTR_FUSE_LOW  = 2'h0;
    localparam logic [1:0] PTR_LOCK      = 2'h1;
    localparam logic [1:0] PTR_FUSE_EXT  = 2'h2;
    localparam logic [1:0] PTR_FUSE_HIGH = 2'h3;
    localparam logic [5:0] LOCK_UNUSED   = 6'h3f;

    // ==========================================
    // flash operation timing
    localparam real CLK_HZ        = 100.0e6;
    localparam real OP_MIN_MS     = 3.7;
    localparam real OP_MAX_MS     = 4.5;
    localparam int  OP_MIN_CYCLES = int'($ceil(OP_MIN_MS * 1.0e-3 * CLK_HZ));
    localparam int  OP_MAX_CYCLES = int'($floor(OP_MAX_MS * 1.0e-3 * CLK_HZ));

    typedef enum logic [1:0] {
        OP_IDLE,
        OP_STREAM,
        OP_WAIT
    } fspc_op_e;
endpackage

// ==== hw/fspc_page_buf.sv ====
`timescale 1ns/1ps
module fspc_page_buf #(
    parameter int WORDS = 32,
    parameter int IW    = 5,
    parameter int DW    = 16
) (
    input  wire logic          clk_i,
    input  wire logic          clear_i,
    input  wire logic          wr_en_i,
    input  wire logic [IW-1:0] wr_idx_i,
    input  wire logic [DW-1:0] wr_data_i,
    input  wire logic [IW-1:0] rd_idx_i,
    output logic      [DW-1:0] rd_data_o
);
    typedef struct packed {
        logic [WORDS-1:0][DW-1:0] mem;
    } fspc_buf_s;

    fspc_buf_s s_r;
    fspc_buf_s s_nxt;

    // ==========================================
    // per-entry update; erased words read all ones like blank flash
    always_comb begin
        s_nxt = s_r;
        for (int i = 0; i < WORDS; i++) begin
            if (clear_i) begin
                s_nxt.mem[i] = '1;
            end else if (wr_en_i && wr_idx_i == IW'(i)) begin
                s_nxt.mem[i] = wr_data_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        s_r <= s_nxt;
    end

    assign rd_data_o = s_r.mem[rd_idx_i];
endmodule

// ==== hw/fspc_flash_self_prog.sv ====
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
// What this block does
// RULE1: ready irq while enable clear, gated
// RULE2: section busy bit always reads zero
// RULE3: section read enable clears page buffer
// RULE4: armed lock read returns lock/fuse bits
// RULE5: armed page write programs buffer to page
// RULE6: page write bit clears at end/timeout
// RULE7: armed page erase erases pointer page
// RULE8: page erase bit clears at end/timeout
// RULE9: cpu stalled for whole erase/write
// RULE10: enable arms store for four cycles
// RULE11: plain enable stores pair into buffer
// RULE12: enable clears on store/timeout, held during op
// RULE13: only five patterns take effect
// RULE14: eeprom write blocks programming and fuse reads
// RULE15: software checks eeprom busy first
// RULE16: lock bits at pointer one, low two bits
// RULE17: lock read bits clear after use/timeout
// RULE18: fuse low, extended, high by pointer
// RULE19: programmed bits read zero, else one
// RULE20: low pointer bits word, high bits page
// RULE21: software uses same page for erase/write
// RULE22: flash operation survives reset
// RULE23: buffer erased after write, reset, eeprom; reset and eeprom clear it only while no flash op runs
// RULE24: operation lasts 3.7 to 4.5 ms
// RULE25: operation length is a parameter
// RULE26: unarmed load returns program byte
module fspc_flash_self_prog
    import fspc_pkg::*;
#(
    parameter int         PAGE_WORDS = 32,
    parameter int         OP_CYCLES  = OP_MIN_CYCLES,
    parameter logic [7:0] FUSE_LOW   = 8'hff,
    parameter logic [7:0] FUSE_HIGH  = 8'hff,
    parameter logic [7:0] FUSE_EXT   = 8'hff,
    parameter logic [1:0] LOCK_BITS  = 2'h3
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        store_instr_i,
    input  wire logic        load_instr_i,
    input  wire logic [15:0] pointer_i,
    input  wire logic [15:0] data_pair_i,
    input  wire logic        eeprom_write_busy_i,
    input  wire logic        global_irq_flag_i,
    input  wire logic [15:0] prog_word_i,
    output logic      [14:0] prog_addr_o,
    output logic      [7:0]  load_data_o,
    output logic             load_valid_o,
    output logic             cpu_stall_o,
    output logic             irq_o,
    output logic             flash_erase_o,
    output logic             flash_wr_o,
    output logic      [14:0] flash_addr_o,
    output logic      [15:0] flash_wdata_o
);
    localparam int WB = $clog2(PAGE_WORDS);
    localparam int PB = 15 - WB;
    localparam int TW = $clog2(OP_CYCLES + 1);

    typedef struct packed {
        logic [7:0]    ctrl;
        logic [2:0]    arm_cnt;
        fspc_op_e      op;
        logic [TW-1:0] timer;
        logic          is_write;
        logic [PB-1:0] page;
        logic [WB-1:0] idx;
        logic          ld_pend;
        logic          ld_special;
        logic          ld_hi;
        logic [7:0]    ld_fixed;
        logic [14:0]   prog_addr;
        logic [7:0]    ld_data;
        logic          ld_valid;
        logic          ack;
        logic [31:0]   dat;
        logic          stall;
        logic          irq;
        logic          f_erase;
        logic          f_wr;
        logic [14:0]   f_addr;
        logic [15:0]   f_wdata;
    } fspc_state_s;

    fspc_state_s   s_r;
    fspc_state_s   s_nxt;
    logic          buf_clr;
    logic          buf_wr;
    logic [15:0]   buf_rd;
    logic          acc_erase;
    logic          acc_write;
    logic          lock_win;
    logic          bus_req;
    logic          csr_wr;
    logic [4:0]    wr_pat;
    logic          pat_ok;

    // ==========================================
    // temporary page buffer
    fspc_page_buf #(
        .WORDS (PAGE_WORDS),
        .IW    (WB),
        .DW    (16)
    ) u_buf (
        .clk_i     (clk_i),
        .clear_i   (buf_clr),
        .wr_en_i   (buf_wr),
        .wr_idx_i  (pointer_i[WB:1]),
        .wr_data_i (data_pair_i),
        .rd_idx_i  (s_r.idx),
        .rd_data_o (buf_rd)
    );

    // ==========================================
    // next state
    always_comb begin
        s_nxt     = s_r;
        buf_clr   = 1'b0;
        buf_wr    = 1'b0;
        acc_erase = 1'b0;
        acc_write = 1'b0;
        bus_req   = wb_cyc_i && wb_stb_i && !s_r.ack;
        wr_pat    = wb_dat_i[4:0];
        pat_ok    = wr_pat == PAT_LOAD || wr_pat == PAT_ERASE || wr_pat == PAT_WRITE
                    || wr_pat == PAT_LOCKRD || wr_pat == PAT_CLRBUF; // see RULE13
        csr_wr    = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == CSR_ADDR;
        lock_win  = s_r.ctrl[BIT_LOCK_RD] && s_r.ctrl[BIT_SPE]
                    && s_r.arm_cnt >= LOAD_WIN;

        // bus answers one cycle after the request, unmapped reads zero
        s_nxt.ack = bus_req;
        s_nxt.dat = 32'h0;
        if (bus_req && wb_adr_i == CSR_ADDR) begin
            s_nxt.dat[7:0] = {s_r.ctrl[BIT_IRQ_EN], 2'b00, s_r.ctrl[4:0]}; // see RULE2
        end

        s_nxt.f_erase  = 1'b0;
        s_nxt.f_wr     = 1'b0;
        s_nxt.ld_valid = 1'b0;

        // arming window runs down; lapse drops the command bits
        if (s_r.op == OP_IDLE && s_r.arm_cnt != 3'h0) begin
            s_nxt.arm_cnt = s_r.arm_cnt - 3'h1;
            // a lock read lapses one cycle sooner than the store window
            if (s_r.arm_cnt == 3'h1
                    || (s_r.arm_cnt == LOAD_WIN && s_r.ctrl[BIT_LOCK_RD])) begin
                s_nxt.ctrl[4:0] = 5'h00; // see RULE6 RULE8 RULE10 RULE12 RULE17
            end
        end

        // store instruction while armed
        if (store_instr_i && s_r.op == OP_IDLE && s_r.arm_cnt != 3'h0
                && !eeprom_write_busy_i) begin // see RULE14
            case (s_r.ctrl[4:0])
                PAT_LOAD: begin
                    buf_wr = 1'b1; // see RULE11
                    s_nxt.ctrl[4:0] = 5'h00;
                    s_nxt.arm_cnt   = 3'h0;
                end
                PAT_ERASE: begin
                    acc_erase      = 1'b1; // see RULE7
                    // a store on the last armed edge must not lose the bits to the lapse
                    s_nxt.ctrl[4:0] = s_r.ctrl[4:0]; // see RULE12
                    s_nxt.op       = OP_WAIT;
                    s_nxt.is_write = 1'b0;
                    s_nxt.page     = pointer_i[15:WB+1]; // see RULE20
                    s_nxt.timer    = TW'(OP_CYCLES); // see RULE24 RULE25
                    s_nxt.f_erase  = 1'b1;
                    s_nxt.f_addr   = {pointer_i[15:WB+1], WB'(0)};
                end
                PAT_WRITE: begin
                    acc_write      = 1'b1; // see RULE5
                    s_nxt.ctrl[4:0] = s_r.ctrl[4:0]; // see RULE12
                    s_nxt.op       = OP_STREAM;
                    s_nxt.is_write = 1'b1;
                    s_nxt.page     = pointer_i[15:WB+1];
                    s_nxt.idx      = WB'(0);
                    s_nxt.timer    = TW'(OP_CYCLES);
                end
                default: begin
                    // lock writes are not supported; the store just completes
                    s_nxt.ctrl[4:0] = 5'h00;
                    s_nxt.arm_cnt   = 3'h0;
                end
            endcase
        end

        // flash operation in progress; cpu held until it ends
        if (s_r.op != OP_IDLE) begin
            s_nxt.timer = s_r.timer - TW'(1);
            if (s_r.op == OP_STREAM) begin
                s_nxt.f_wr    = 1'b1;
                s_nxt.f_addr  = {s_r.page, s_r.idx};
                s_nxt.f_wdata = buf_rd;
                s_nxt.idx     = s_r.idx + WB'(1);
                if (s_r.idx == WB'(PAGE_WORDS - 1)) begin
                    s_nxt.op = OP_WAIT;
                end
            end
            if (s_r.timer == TW'(1)) begin
                s_nxt.op        = OP_IDLE;
                s_nxt.ctrl[4:0] = 5'h00; // see RULE6 RULE8 RULE12
                s_nxt.arm_cnt   = 3'h0;
                buf_clr         = s_r.is_write; // see RULE23
            end
        end
        s_nxt.stall = s_nxt.op != OP_IDLE; // see RULE9

        // load instruction: fuse and lock read when armed
        s_nxt.ld_pend = 1'b0;
        if (load_instr_i) begin
            s_nxt.ld_pend    = 1'b1;
            s_nxt.prog_addr  = pointer_i[15:1];
            s_nxt.ld_hi      = pointer_i[0];
            s_nxt.ld_special = lock_win;
            s_nxt.ld_fixed   = 8'hff; // blocked reads show all ones
            if (lock_win) begin
                if (!eeprom_write_busy_i) begin // see RULE14
                    case (pointer_i[1:0]) // see RULE4 RULE18 RULE19
                        PTR_FUSE_LOW:  s_nxt.ld_fixed = FUSE_LOW;
                        PTR_LOCK:      s_nxt.ld_fixed = {LOCK_UNUSED, LOCK_BITS}; // see RULE16
                        PTR_FUSE_EXT:  s_nxt.ld_fixed = FUSE_EXT;
                        PTR_FUSE_HIGH: s_nxt.ld_fixed = FUSE_HIGH;
                        default:       s_nxt.ld_fixed = 8'hff;
                    endcase
                end
                s_nxt.ctrl[4:0] = 5'h00; // see RULE17
                s_nxt.arm_cnt   = 3'h0;
            end
        end
        if (s_r.ld_pend) begin
            s_nxt.ld_valid = 1'b1;
            if (s_r.ld_special) begin
                s_nxt.ld_data = s_r.ld_fixed;
            end else begin
                s_nxt.ld_data = s_r.ld_hi ? prog_word_i[15:8] : prog_word_i[7:0]; // see RULE26
            end
        end

        // software write; refused while an eeprom write or a flash op runs
        if (csr_wr && s_r.op == OP_IDLE && !eeprom_write_busy_i) begin
            s_nxt.ctrl[BIT_IRQ_EN] = wb_dat_i[BIT_IRQ_EN];
            if (pat_ok) begin // see RULE13
                s_nxt.ctrl[4:0] = wr_pat;
                s_nxt.arm_cnt   = ARM_CYCLES; // see RULE10
                if (wr_pat == PAT_CLRBUF) begin
                    buf_clr = 1'b1; // see RULE3
                end
            end
        end

        // eeprom write discards loaded words
        if (eeprom_write_busy_i && s_r.op == OP_IDLE) begin
            buf_clr = 1'b1; // see RULE23
        end

        s_nxt.irq = s_nxt.ctrl[BIT_IRQ_EN] && global_irq_flag_i
                    && !s_nxt.ctrl[BIT_SPE]; // see RULE1

        // reset leaves a running flash operation to finish;
        // an unknown state at power-up falls into the idle branch
        if (rst_i) begin
            s_nxt.ctrl       = CSR_RESET;
            s_nxt.arm_cnt    = 3'h0;
            s_nxt.ld_pend    = 1'b0;
            s_nxt.ld_special = 1'b0;
            s_nxt.ld_hi      = 1'b0;
            s_nxt.ld_fixed   = 8'h00;
            s_nxt.prog_addr  = 15'h0000;
            s_nxt.ld_data    = 8'h00;
            s_nxt.ld_valid   = 1'b0;
            s_nxt.ack        = 1'b0;
            s_nxt.dat        = 32'h0;
            s_nxt.irq        = 1'b0;
            if (s_r.op != OP_IDLE) begin
                s_nxt.ctrl[4:0] = s_r.ctrl[4:0]; // see RULE22
            end else begin
                buf_clr        = 1'b1; // see RULE23
                s_nxt.op       = OP_IDLE;
                s_nxt.timer    = TW'(0);
                s_nxt.is_write = 1'b0;
                s_nxt.page     = PB'(0);
                s_nxt.idx      = WB'(0);
                s_nxt.stall    = 1'b0;
                s_nxt.f_erase  = 1'b0;
                s_nxt.f_wr     = 1'b0;
                s_nxt.f_addr   = 15'h0000;
                s_nxt.f_wdata  = 16'h0000;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        s_r <= s_nxt;
    end

    assign wb_dat_o      = s_r.dat;
    assign wb_ack_o      = s_r.ack;
    assign prog_addr_o   = s_r.prog_addr;
    assign load_data_o   = s_r.ld_data;
    assign load_valid_o  = s_r.ld_valid;
    assign cpu_stall_o   = s_r.stall;
    assign irq_o         = s_r.irq;
    assign flash_erase_o = s_r.f_erase;
    assign flash_wr_o    = s_r.f_wr;
    assign flash_addr_o  = s_r.f_addr;
    assign flash_wdata_o = s_r.f_wdata;

    // ==========================================
    // checks
    chk_busy_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE2
        wb_ack_o |-> !wb_dat_o[BIT_BUSY])
        else $error("section busy bit read as one");

    chk_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE1
        s_r.ctrl[BIT_SPE] |-> !irq_o)
        else $error("ready irq raised while enable set");

    chk_arm_lapse: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE10
        (s_r.arm_cnt == ARM_CYCLES && s_r.op == OP_IDLE && !store_instr_i
         && !load_instr_i && !csr_wr) ##1 (!store_instr_i && !load_instr_i && !csr_wr)[*3]
        |=> !s_r.ctrl[BIT_SPE])
        else $error("enable bit did not lapse after four cycles");

    chk_stall_hold: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE9
        (acc_erase || acc_write) |=> cpu_stall_o [*4])
        else $error("cpu not stalled during flash operation");

    chk_spe_during_op: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE12
        s_r.op != OP_IDLE |-> s_r.ctrl[BIT_SPE])
        else $error("enable bit fell during flash operation");

    chk_erase_page: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE7
        acc_erase |=> flash_erase_o && flash_addr_o[14:WB] == $past(pointer_i[15:WB+1]))
        else $error("erase went to wrong page");

    chk_write_start: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE5
        acc_write |=> ##1 flash_wr_o && flash_addr_o[WB-1:0] == WB'(0))
        else $error("page write did not start at word zero");

    chk_lock_read: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE16
        (load_instr_i && lock_win && pointer_i[1:0] == PTR_LOCK && !eeprom_write_busy_i)
        |=> ##1 load_valid_o && load_data_o == {LOCK_UNUSED, LOCK_BITS})
        else $error("lock bits not returned");

    chk_eeprom_block: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE14
        (s_r.op == OP_IDLE && eeprom_write_busy_i) |=> s_r.op == OP_IDLE)
        else $error("flash op started during eeprom write");
endmodule

// ==== verification/fspc_cpu_model.sv ====
`timescale 1ns/1ps
// ==========================================
// cpu core side: store and load program instructions
module fspc_cpu_model (
    input  wire logic        clk_i,
    input  wire logic [14:0] prog_addr_i,
    input  wire logic [7:0]  load_data_i,
    input  wire logic        load_valid_i,
    input  wire logic        stall_i,
    output logic             store_instr_o,
    output logic             load_instr_o,
    output logic      [15:0] pointer_o,
    output logic      [15:0] data_pair_o,
    output logic      [15:0] prog_word_o
);
    initial begin
        store_instr_o = 1'b0;
        load_instr_o  = 1'b0;
        pointer_o     = 16'h0000;
        data_pair_o   = 16'h0000;
    end

    // program memory image, byte pattern differs per half
    assign prog_word_o = {prog_addr_i[7:0] ^ 8'ha5, prog_addr_i[7:0]};

    // a halted core issues no store; released lines show the inverse
    task automatic store(input logic [15:0] p, input logic [15:0] d);
        int i;
        i = 0;
        while (stall_i === 1'b1 && i < 500) begin
            @(posedge clk_i);
            i++;
        end
        store_instr_o <= 1'b1;
        pointer_o     <= p;
        data_pair_o   <= d;
        @(posedge clk_i);
        store_instr_o <= 1'b0;
        pointer_o     <= ~p;
        data_pair_o   <= ~d;
    endtask

    task automatic load(input logic [15:0] p, output logic [7:0] q);
        int i;
        i = 0;
        load_instr_o <= 1'b1;
        pointer_o    <= p;
        @(posedge clk_i);
        load_instr_o <= 1'b0;
        pointer_o    <= ~p;
        while (load_valid_i !== 1'b1 && i < 8) begin
            @(posedge clk_i);
            i++;
        end
        q = (i < 8) ? load_data_i : 8'hxx;
    endtask
endmodule

// ==== verification/flash_self_program_control_tb_top.sv ====
`timescale 1ns/1ps
module flash_self_program_control_tb_top;
    localparam int         OPC  = 64;
    localparam int         PW   = 32;
    localparam logic [7:0] F_LO = 8'h62;
    localparam logic [7:0] F_HI = 8'hdf;
    localparam logic [7:0] F_EX = 8'hf9;
    localparam logic [1:0] LKB  = 2'h2;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0]  adr = 4'h0, sel = 4'h0;
    logic [31:0] dat_w = 32'h0, dat_r;
    logic        ack, store, load, lvalid, stall, irq, ferase, fwr;
    logic        ee_busy = 1'b0;
    logic        gflag = 1'b1;
    logic [15:0] ptr, pair, pword, fwdata;
    logic [14:0] paddr, faddr;
    logic [7:0]  ldata, q;
    logic [9:0]  exp_pg;
    logic [15:0] exp_buf [PW];
    logic [7:0]  spec [4] = '{F_LO, {6'h3f, LKB}, F_EX, F_HI};
    int          num_errors = 0, n_compared = 0, n_stall = 0, n_er = 0, n_wr = 0;

    always #5 clk_i = ~clk_i;

    fspc_flash_self_prog #(.OP_CYCLES(OPC), .PAGE_WORDS(PW), .FUSE_LOW(F_LO),
        .FUSE_HIGH(F_HI), .FUSE_EXT(F_EX), .LOCK_BITS(LKB)) fspc_flash_self_prog_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .store_instr_i(store), .load_instr_i(load), .pointer_i(ptr), .data_pair_i(pair),
        .eeprom_write_busy_i(ee_busy), .global_irq_flag_i(gflag), .prog_word_i(pword),
        .prog_addr_o(paddr), .load_data_o(ldata), .load_valid_o(lvalid), .cpu_stall_o(stall),
        .irq_o(irq), .flash_erase_o(ferase), .flash_wr_o(fwr), .flash_addr_o(faddr),
        .flash_wdata_o(fwdata));

    fspc_cpu_model fspc_cpu_model_inst (
        .clk_i(clk_i), .prog_addr_i(paddr), .load_data_i(ldata), .load_valid_i(lvalid),
        .stall_i(stall), .store_instr_o(store), .load_instr_o(load), .pointer_o(ptr),
        .data_pair_o(pair), .prog_word_o(pword));

    // ==========================================
    // shared tasks
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic close_out;
        if (num_errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
                      output logic [7:0] r);
        int i;
        i = 0;
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        sel   <= 4'h1;
        dat_w <= {24'h0, d};
        @(posedge clk_i);
        while (ack !== 1'b1 && i < 20) begin
            @(posedge clk_i);
            i++;
        end
        if (i == 20) num_errors++;
        r = dat_r[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] d);
        logic [7:0] x;
        wb(1'b1, 4'h0, d, x);
    endtask

    task automatic rdc(input logic [7:0] e);
        logic [7:0] x;
        wb(1'b0, 4'h0, 8'h00, x);
        check("csr", 32'(x), 32'(e));
    endtask

    task automatic clr;
        n_stall = 0;
        n_er = 0;
        n_wr = 0;
    endtask

    task automatic idle;
        int i;
        i = 0;
        repeat (3) @(posedge clk_i);
        while (stall !== 1'b0 && i < 500) begin
            @(posedge clk_i);
            i++;
        end
        @(posedge clk_i);
    endtask

    function automatic logic [7:0] pbyte(input logic [15:0] p);
        return p[0] ? (p[8:1] ^ 8'ha5) : p[8:1];
    endfunction

    // ==========================================
    // flash side monitor
    always @(posedge clk_i) begin
        if (stall === 1'b1) n_stall++;
        if (ferase === 1'b1) begin
            n_er++;
            check("erase_addr", 32'(faddr), 32'({exp_pg, 5'h0}));
        end
        if (fwr === 1'b1) begin
            check("wr_addr", 32'(faddr), 32'({exp_pg, n_wr[4:0]}));
            check("wr_data", 32'(fwdata), 32'(exp_buf[n_wr[4:0]]));
            n_wr++;
        end
    end

    // ==========================================
    // scenarios
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc(8'h00);
        wb(1'b1, 4'h4, 8'h81, q);
        wb(1'b0, 4'h4, 8'h00, q);
        check("unmapped", 32'(q), 32'h0);
        rdc(8'h00);
        wr(8'hc0);
        rdc(8'h80);
        check("irq_on", 32'(irq), 32'h1);
        gflag <= 1'b0;
        repeat (2) @(posedge clk_i);
        check("irq_gated", 32'(irq), 32'h0);
        gflag <= 1'b1;
        exp_pg = 10'h005;
        foreach (exp_buf[k]) exp_buf[k] = 16'hffff;
        exp_buf[3] = 16'h1234;
        wr(8'h81);
        check("irq_armed", 32'(irq), 32'h0);
        fspc_cpu_model_inst.store(16'h0147, 16'h1234);
        rdc(8'h80);
        clr();
        wr(8'h83);
        fspc_cpu_model_inst.store(16'h017f, 16'hbeef);
        rdc(8'h83);
        idle();
        check("erase_cnt", 32'(n_er), 32'h1);
        check("erase_stall", 32'(n_stall), 32'(OPC));
        rdc(8'h80);
        clr();
        wr(8'h85);
        fspc_cpu_model_inst.store(16'h0140, 16'hdead);
        idle();
        check("wr_cnt", 32'(n_wr), 32'(PW));
        check("wr_stall", 32'(n_stall), 32'(OPC));
        rdc(8'h80);
        wr(8'h81);
        fspc_cpu_model_inst.store(16'h0148, 16'h5555);
        wr(8'h91);
        repeat (5) @(posedge clk_i);
        foreach (exp_buf[k]) exp_buf[k] = 16'hffff;
        exp_pg = 10'h006;
        clr();
        wr(8'h85);
        fspc_cpu_model_inst.store(16'h0180, 16'h0000);
        idle();
        check("clr_cnt", 32'(n_wr), 32'(PW));
        clr();
        wr(8'h85);
        repeat (4) @(posedge clk_i);
        fspc_cpu_model_inst.store(16'h0180, 16'h0000);
        repeat (6) @(posedge clk_i);
        check("lapse", 32'(n_stall), 32'h0);
        rdc(8'h80);
        for (int p = 0; p < 4; p++) begin
            wr(8'h89);
            fspc_cpu_model_inst.load(16'(p), q);
            check("fuse_lock", 32'(q), 32'(spec[p]));
        end
        rdc(8'h80);
        wr(8'h89);
        @(posedge clk_i);
        fspc_cpu_model_inst.load(16'h0003, q);
        check("lapsed_load", 32'(q), 32'(pbyte(16'h0003)));
        fspc_cpu_model_inst.load(16'h0a51, q);
        check("plain_load", 32'(q), 32'(pbyte(16'h0a51)));
        wr(8'h89);
        ee_busy <= 1'b1;
        fspc_cpu_model_inst.load(16'h0001, q);
        check("ee_load", 32'(q), 32'h000000ff);
        repeat (4) @(posedge clk_i);
        wr(8'h83);
        rdc(8'h80);
        ee_busy <= 1'b0;
        clr();
        wr(8'h83);
        ee_busy <= 1'b1;
        fspc_cpu_model_inst.store(16'h0140, 16'h0000);
        repeat (6) @(posedge clk_i);
        check("ee_store", 32'(n_er), 32'h0);
        ee_busy <= 1'b0;
        clr();
        exp_pg = 10'h007;
        wr(8'h83);
        @(posedge clk_i);
        fspc_cpu_model_inst.store(16'h01c0, 16'h0000);
        rdc(8'h83);
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        idle();
        check("rst_erase", 32'(n_er), 32'h1);
        check("rst_stall", 32'(n_stall), 32'(OPC));
        rdc(8'h00);
        close_out();
    end

    // hang guard, far beyond the few hundred cycles the run needs
    initial begin
        #200000;
        num_errors++;
        close_out();
    end
endmodule
